//--- qdc_pkg.sv
// Purpose: Shared constants of the quad DAC serial command port.
// Assumes: 40 MHz system clock; AXI4-Lite register access.
// Notes: Offsets, action codes, frame and status field positions and the pin, code and echo reset values live here.
package qdc_pkg;
  // ********************************************************
  // Frame layout
  // ********************************************************
  localparam int FRAME_W = 16;           // Bits per command frame
  localparam int CODE_W = 12;            // DAC code width
  localparam int CODE_MSB = 15;          // Top of the 4-bit action code
  localparam int CODE_LSB = 12;          // Bottom of the 4-bit action code
  localparam int NUM_CH = 4;             // Channels A through D
  // ********************************************************
  // Action codes (channel select + control)
  // ********************************************************
  localparam logic [1:0] CTL_LOAD = 2'h1;       // Load input register only
  localparam logic [1:0] CTL_LOAD_UPD = 2'h3;   // Load input, update all
  localparam logic [3:0] CMD_NOP = 4'h0;        // No operation
  localparam logic [3:0] CMD_OUT_LOW = 4'h2;    // User output low
  localparam logic [3:0] CMD_RECALL = 4'h4;     // Inputs to DACs, wake
  localparam logic [3:0] CMD_OUT_HIGH = 4'h6;   // User output high
  localparam logic [3:0] CMD_BROADCAST = 4'h8;  // Data to all registers
  localparam logic [3:0] CMD_ECHO_FALL = 4'hA;  // Echo mode 0, update all
  localparam logic [3:0] CMD_SHUTDOWN = 4'hC;   // Shutdown if allowed
  localparam logic [3:0] CMD_ECHO_RISE = 4'hE;  // Echo mode 1, update all
  // ********************************************************
  // Register map (byte addresses)
  // ********************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;      // W: bit0 soft clear
  localparam logic [7:0] OFS_STATUS = 8'h04;    // R: live state
  localparam logic [7:0] OFS_LAST = 8'h08;      // R: last decoded frame
  localparam logic [7:0] OFS_DAC_BASE = 8'h10;  // R: DAC registers A..D
  localparam logic [7:0] OFS_IN_BASE = 8'h20;   // R: input registers A..D
  localparam logic [7:0] OFS_BANK_MASK = 8'hF0; // Selects a bank of four
  localparam int CTRL_SOFT_CLR = 0;             // Soft clear bit
  localparam int ST_SHUTDOWN = 0;               // Status: shut down
  localparam int ST_ECHO_MODE = 1;              // Status: echo mode
  localparam int ST_USER_OUT = 2;               // Status: user output
  localparam int ST_SEL_LOW = 3;                // Status: frame open
  localparam int ST_CNT_LSB = 16;               // Status: frame count
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ********************************************************
  // Reset values
  // ********************************************************
  localparam logic [4:0] PIN_RST = 5'h1C;       // Idle pin levels
  localparam logic [11:0] CODE_RST = 12'h000;   // Zero code
  localparam logic ECHO_MODE_RST = 1'b0;        // Falling-edge echo
endpackage : qdc_pkg

//--- qdc_pin_if.sv
// Purpose: Carries synchronised link events from the pin stage to the core.
// Assumes: All signals are on the system clock.
// Notes: Edge flags are one-cycle pulses.
`timescale 1ns/1ps
interface qdc_pin_if;
  logic sel_low;       // Select held low (frame open)
  logic sel_rise;      // Select rose: decode now
  logic sck_rise;      // Shift clock rising edge
  logic sck_fall;      // Shift clock falling edge
  logic din;           // Serial data level
  logic clear_n;       // Clear level, active low
  logic lockout_n;     // Shutdown lockout level, active low
  logic lockout_fall;  // Lockout went high to low
  modport sync (output sel_low, sel_rise, sck_rise, sck_fall, din, clear_n, lockout_n, lockout_fall);
  modport core (input sel_low, sel_rise, sck_rise, sck_fall, din, clear_n, lockout_n, lockout_fall);
endinterface : qdc_pin_if

//--- qdc_pin_sync.sv
// Purpose: Two-flop synchronisers and edge finders for the link pins.
// Assumes: Link clock well below a quarter of the system clock.
// Notes: Edge detectors look only at stage two and stage three.
`timescale 1ns/1ps
module qdc_pin_sync (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_shift_clk,
  input wire logic i_serial_in,
  input wire logic i_select_n,
  input wire logic i_clear_all_n,
  input wire logic i_shutdown_lockout_n,
  qdc_pin_if.sync pins
);
  // ********************************************************
  // State
  // ********************************************************
  typedef struct packed {
    logic [4:0] meta;  // First stage, read only by stage two
    logic [4:0] sync;  // Second stage, safe to use
    logic [4:0] prev;  // Delayed copy for edge finding
  } qdc_sync_t;
  qdc_sync_t st;
  qdc_sync_t next_st;
  logic [4:0] raw;     // Pin bundle

  assign raw = {i_shutdown_lockout_n, i_clear_all_n, i_select_n, i_serial_in, i_shift_clk};

  // Per-pin shift through the three stages
  generate
    for (genvar b = 0; b < 5; b++) begin : g_pin
      always_comb begin
        next_st.meta[b] = raw[b];
        next_st.sync[b] = st.meta[b];
        next_st.prev[b] = st.sync[b];
      end
    end
  endgenerate

  // Register; reset loads the idle levels so no false edge appears
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      st <= {qdc_pkg::PIN_RST, qdc_pkg::PIN_RST, qdc_pkg::PIN_RST};
    end else begin
      st <= next_st;
    end
  end

  // ********************************************************
  // Events
  // ********************************************************
  assign pins.sck_rise = st.sync[0] & ~st.prev[0];
  assign pins.sck_fall = ~st.sync[0] & st.prev[0];
  assign pins.din = st.sync[1];
  assign pins.sel_low = ~st.sync[2];
  assign pins.sel_rise = st.sync[2] & ~st.prev[2];
  assign pins.clear_n = st.sync[3];
  assign pins.lockout_n = st.sync[4];
  assign pins.lockout_fall = ~st.sync[4] & st.prev[4];
endmodule : qdc_pin_sync

//--- qdc_dac_port.sv
// Purpose: Serial command port and register core of a quad 12-bit DAC.
// Assumes: Link pins are asynchronous and slow against i_clk_sys.
// Notes: Analog behaviour is out of scope; DAC codes leave as words.
`timescale 1ns/1ps
module qdc_dac_port (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Link pins
  input wire logic i_shift_clk,
  input wire logic i_serial_in,
  input wire logic i_select_n,
  input wire logic i_clear_all_n,
  input wire logic i_shutdown_lockout_n,
  output logic o_echo_out,
  output logic o_user_logic_out,
  // Converter side
  output logic [47:0] o_dac_code,
  output logic o_shutdown,
  output logic o_echo_mode,
  // AXI4-Lite slave
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready
);
  // ********************************************************
  // State
  // ********************************************************
  typedef struct packed {
    logic [3:0][11:0] in_reg;   // Input registers A..D
    logic [3:0][11:0] dac_reg;  // DAC registers A..D
    logic [15:0] shreg;         // Serial shift register
    logic held_msb;             // MSB before the last rise
    logic echo;                 // Echo pin level
    logic echo_mode;            // 0: fall edge, 1: rise edge
    logic shutdown;             // Converter shut down
    logic user_out;             // User logic output
    logic [15:0] last_frame;    // Last decoded frame
    logic [15:0] frame_cnt;     // Decoded frames, wraps
    logic aw_held;              // Write address taken
    logic [7:0] aw_addr;        // Held write address
    logic w_held;               // Write data taken
    logic [31:0] w_data;        // Held write data
    logic [3:0] w_strb;         // Held byte strobes
    logic bvalid;               // Write answer pending
    logic [1:0] bresp;          // Write answer code
    logic rvalid;               // Read answer pending
    logic [31:0] rdata;         // Read answer data
    logic [1:0] rresp;          // Read answer code
  } qdc_core_t;

  qdc_core_t st;       // Registered state
  qdc_core_t next_st;  // Next state
  qdc_pin_if pins();   // Synchronised link events

  // ********************************************************
  // Pin synchroniser
  // ********************************************************
  qdc_pin_sync u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_shift_clk(i_shift_clk),
    .i_serial_in(i_serial_in),
    .i_select_n(i_select_n),
    .i_clear_all_n(i_clear_all_n),
    .i_shutdown_lockout_n(i_shutdown_lockout_n),
    .pins(pins)
  );

  // ********************************************************
  // Helpers
  // ********************************************************
  logic [3:0] code;        // Action code of the frame
  logic [1:0] chan;        // Channel select field
  logic [1:0] ctl;         // Control field
  logic [11:0] data;       // DAC code field
  logic wr_go;             // Address and data both held
  logic soft_clr;          // Software clear this cycle
  logic [31:0] status;     // Status word
  logic [31:0] rd_word;    // Read mux output
  logic rd_hit;            // Read address mapped

  assign code = st.shreg[qdc_pkg::CODE_MSB:qdc_pkg::CODE_LSB];
  assign chan = code[3:2];
  assign ctl = code[1:0];
  assign data = st.shreg[qdc_pkg::CODE_W-1:0];
  assign wr_go = st.aw_held & st.w_held & ~st.bvalid;
  // Soft clear fires on the cycle the write completes
  assign soft_clr = wr_go & (st.aw_addr == qdc_pkg::OFS_CTRL) & st.w_strb[0]
                    & st.w_data[qdc_pkg::CTRL_SOFT_CLR];

  // Status word assembly
  always_comb begin
    status = 32'h0000_0000;
    status[qdc_pkg::ST_SHUTDOWN] = st.shutdown;
    status[qdc_pkg::ST_ECHO_MODE] = st.echo_mode;
    status[qdc_pkg::ST_USER_OUT] = st.user_out;
    status[qdc_pkg::ST_SEL_LOW] = pins.sel_low;
    status[qdc_pkg::ST_CNT_LSB +: 16] = st.frame_cnt;
  end

  // Read decode; unmapped reads return zero with an error answer
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    if (i_araddr[1:0] != 2'h0) begin
      rd_hit = 1'b0;
    end else if (i_araddr == qdc_pkg::OFS_CTRL) begin
      rd_word = 32'h0000_0000;
    end else if (i_araddr == qdc_pkg::OFS_STATUS) begin
      rd_word = status;
    end else if (i_araddr == qdc_pkg::OFS_LAST) begin
      rd_word = {16'h0000, st.last_frame};
    end else if ((i_araddr & qdc_pkg::OFS_BANK_MASK) == qdc_pkg::OFS_DAC_BASE) begin
      rd_word = {20'h00000, st.dac_reg[i_araddr[3:2]]};
    end else if ((i_araddr & qdc_pkg::OFS_BANK_MASK) == qdc_pkg::OFS_IN_BASE) begin
      rd_word = {20'h00000, st.in_reg[i_araddr[3:2]]};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // ********************************************************
  // Next-state logic
  // ********************************************************
  // Link first, then clear sources, then the bus. Clear comes
  // after the link so it wins over a frame decoded in the same
  // cycle, except for echo mode, last_frame and frame_cnt.
  always_comb begin
    next_st = st;

    // Shift only inside a frame; select high leaves it frozen
    if (pins.sel_low && pins.sck_rise) begin
      next_st.held_msb = st.shreg[qdc_pkg::FRAME_W-1];
      // Older bits fall off the top, so only the last 16 remain
      next_st.shreg = {st.shreg[qdc_pkg::FRAME_W-2:0], pins.din};
      // Rise mode: the bit shifted out now, 16 clocks old
      if (st.echo_mode) begin
        next_st.echo = st.shreg[qdc_pkg::FRAME_W-1];
      end
    end

    // Fall mode: half a clock later, 16.5 clocks old
    if (pins.sel_low && pins.sck_fall && !st.echo_mode) begin
      next_st.echo = st.held_msb;
    end

    // Decode happens only at the select rise; shutdown leaves
    // the port running and the inputs untouched
    if (pins.sel_rise) begin
      next_st.last_frame = st.shreg;
      next_st.frame_cnt = st.frame_cnt + 16'h0001;
      if (ctl == qdc_pkg::CTL_LOAD) begin
        // Input register only; DACs hold
        next_st.in_reg[chan] = data;
      end else if (ctl == qdc_pkg::CTL_LOAD_UPD) begin
        // Load, then all DACs take the new input set
        next_st.in_reg[chan] = data;
        for (int c = 0; c < qdc_pkg::NUM_CH; c++) begin
          next_st.dac_reg[c] = (c == int'(chan)) ? data : st.in_reg[c];
        end
        next_st.shutdown = 1'b0;
      end else begin
        case (code)
          qdc_pkg::CMD_RECALL: begin
            next_st.dac_reg = st.in_reg;
            next_st.shutdown = 1'b0;
          end
          qdc_pkg::CMD_BROADCAST: begin
            for (int c = 0; c < qdc_pkg::NUM_CH; c++) begin
              next_st.in_reg[c] = data;
              next_st.dac_reg[c] = data;
            end
            next_st.shutdown = 1'b0;
          end
          qdc_pkg::CMD_SHUTDOWN: begin
            // A low lockout level refuses the request silently
            if (pins.lockout_n) begin
              next_st.shutdown = 1'b1;
            end
          end
          qdc_pkg::CMD_OUT_LOW: begin
            next_st.user_out = 1'b0;
          end
          qdc_pkg::CMD_OUT_HIGH: begin
            next_st.user_out = 1'b1;
          end
          qdc_pkg::CMD_ECHO_RISE: begin
            next_st.echo_mode = 1'b1;
            next_st.dac_reg = st.in_reg;
            next_st.shutdown = 1'b0;
          end
          qdc_pkg::CMD_ECHO_FALL: begin
            next_st.echo_mode = 1'b0;
            next_st.dac_reg = st.in_reg;
            next_st.shutdown = 1'b0;
          end
          qdc_pkg::CMD_NOP: begin
            // Pass-through frame for a chained neighbour
            next_st.dac_reg = st.dac_reg;
          end
          default: begin
            // Undefined codes act as no operation
            next_st.dac_reg = st.dac_reg;
          end
        endcase
      end
    end

    // Lockout falling while shut down wakes with old outputs
    if (st.shutdown && pins.lockout_fall) begin
      next_st.shutdown = 1'b0;
    end

    // Clear pin or software clear: zero all codes and outputs.
    // Echo mode is kept: only reset or an echo-fall frame restores its default.
    if (!pins.clear_n || soft_clr) begin
      for (int c = 0; c < qdc_pkg::NUM_CH; c++) begin
        next_st.in_reg[c] = qdc_pkg::CODE_RST;
        next_st.dac_reg[c] = qdc_pkg::CODE_RST;
      end
      next_st.user_out = 1'b0;
      next_st.echo = 1'b0;
      next_st.held_msb = 1'b0;
      next_st.shreg = 16'h0000;
      next_st.shutdown = 1'b0;
    end

    // ---- AXI4-Lite write path ----
    // Address and data are taken independently, in any order
    if (i_awvalid && !st.aw_held && !st.bvalid) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = i_awaddr;
    end
    if (i_wvalid && !st.w_held && !st.bvalid) begin
      next_st.w_held = 1'b1;
      next_st.w_data = i_wdata;
      next_st.w_strb = i_wstrb;
    end
    // Both held: perform the write and raise the answer
    if (wr_go) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      // Only the control word is writable; the rest refuse
      next_st.bresp = (st.aw_addr == qdc_pkg::OFS_CTRL) ? qdc_pkg::RESP_OKAY : qdc_pkg::RESP_SLVERR;
    end
    if (st.bvalid && i_bready) begin
      next_st.bvalid = 1'b0;
    end

    // ---- AXI4-Lite read path ----
    // One read in flight; data is captured at acceptance
    if (i_arvalid && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_word;
      next_st.rresp = rd_hit ? qdc_pkg::RESP_OKAY : qdc_pkg::RESP_SLVERR;
    end else if (st.rvalid && i_rready) begin
      next_st.rvalid = 1'b0;
    end
  end

  // ********************************************************
  // State register
  // ********************************************************
  // Reset puts every code at zero and echo in fall mode
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      st <= '0;
      st.echo_mode <= qdc_pkg::ECHO_MODE_RST;
    end else begin
      st <= next_st;
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  // Handshake readies are combinational; data from flops
  assign o_awready = ~st.aw_held & ~st.bvalid;
  assign o_wready = ~st.w_held & ~st.bvalid;
  assign o_arready = ~st.rvalid;
  assign o_bvalid = st.bvalid;
  assign o_bresp = st.bresp;
  assign o_rvalid = st.rvalid;
  assign o_rdata = st.rdata;
  assign o_rresp = st.rresp;
  assign o_dac_code = st.dac_reg;
  assign o_shutdown = st.shutdown;
  assign o_echo_mode = st.echo_mode;
  assign o_echo_out = st.echo;
  assign o_user_logic_out = st.user_out;
endmodule : qdc_dac_port

//--- qdc_dac_port_checker.sv
// Purpose: Concurrent checks on the quad DAC command port.
// Assumes: Pin effects settle within eight system clocks.
// Notes: Sees only the top ports; bound at the foot of this file.
`timescale 1ns/1ps
module qdc_dac_port_checker (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_select_n,
  input wire logic i_clear_all_n,
  input wire logic i_shutdown_lockout_n,
  input wire logic o_echo_out,
  input wire logic o_user_logic_out,
  input wire logic [47:0] o_dac_code,
  input wire logic o_shutdown,
  input wire logic o_echo_mode,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic i_rready
);
  // *****
  // Checks
  // *****
  // One domain: clock and reset stated once
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // Eight quiet cycles cover the select sync delay
  chk_sel_quiet: assert property (
    (i_select_n && i_clear_all_n)[*8] |=> $stable({o_dac_code, o_user_logic_out, o_echo_mode}))
    else $error("State moved with select high");
  chk_echo_quiet: assert property (
    (i_select_n && i_clear_all_n)[*8] |=> $stable(o_echo_out)) else $error("Echo moved with select high");
  chk_clear_zero: assert property (
    (!i_clear_all_n)[*6] |-> (o_dac_code == 48'h0 && !o_user_logic_out && !o_echo_out && !o_shutdown))
    else $error("Clear did not zero outputs");
  chk_lock_block: assert property (
    (!i_shutdown_lockout_n)[*6] |-> !$rose(o_shutdown)) else $error("Shutdown entered while locked out");
  chk_reset_zero: assert property (
    $past(i_rst) |-> (o_dac_code == 48'h0 && !o_shutdown && !o_echo_mode && !o_user_logic_out && !o_bvalid))
    else $error("Reset values wrong");
  // Write answer two edges after both are taken
  chk_wr_answer: assert property (
    i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid) else $error("Write answer late");
  chk_b_hold: assert property (
    o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp)) else $error("Write answer dropped");
  chk_r_hold: assert property (
    o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata)) else $error("Read answer dropped");
  chk_rd_answer: assert property (
    i_arvalid && o_arready |=> o_rvalid) else $error("Read answer late");
  cover property ($rose(o_shutdown));
  cover property ($rose(o_echo_mode));
  cover property ($fell(o_shutdown) && !i_shutdown_lockout_n);
endmodule // qdc_dac_port_checker

bind qdc_dac_port qdc_dac_port_checker i_qdc_dac_port_checker (.*);

//--- qdc_host_model.sv
// Purpose: Host serial master driving the command port link pins.
// Assumes: Pins change just after i_clk_sys rises.
// Notes: Shift clock rests low between frames; idle data shows the inverse.
`timescale 1ns/1ps
module qdc_host_model (
  input wire logic i_clk_sys,
  input wire logic i_echo_out,
  output logic o_shift_clk,
  output logic o_serial_in,
  output logic o_select_n
);
  // *****
  // Frame driver
  // *****
  initial begin
    o_shift_clk = 1'b0;
    o_serial_in = 1'b0;
    o_select_n = 1'b1;
  end
  // Sends the low n bits of w; open low clocks with select high
  // Echo is sampled at the end of each high phase
  task automatic send(input logic [31:0] w, input int n, input logic open, input int half, output logic [15:0] cap);
    cap = 16'h0;
    @(posedge i_clk_sys);
    o_select_n <= !open;
    for (int i = n - 1; i >= 0; i--) begin
      o_serial_in <= w[i];
      repeat (half) @(posedge i_clk_sys);
      o_shift_clk <= 1'b1;
      repeat (half) @(posedge i_clk_sys);
      cap = {cap[14:0], i_echo_out};
      o_shift_clk <= 1'b0;
    end
    // Select rises after the last fall
    repeat (half) @(posedge i_clk_sys);
    o_select_n <= 1'b1;
    o_serial_in <= ~w[0];
  endtask
endmodule // qdc_host_model

//--- qdc_dac_port_tb_top.sv
// Purpose: Self-checking bench for the quad DAC command port.
// Assumes: 40 MHz clock; 200 ns link clock from the host model, 400 ns in the echo test.
// Notes: Expected state is updated per frame.
`timescale 1ns/1ps
module qdc_dac_port_tb_top;
  // *****
  // Signals
  // *****
  logic i_clk_sys, i_rst, i_clear_all_n, i_shutdown_lockout_n;
  logic i_shift_clk, i_serial_in, i_select_n; // Driven by the host model
  logic [7:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata, rd;
  logic [3:0] i_wstrb;
  logic i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic o_echo_out, o_user_logic_out, o_shutdown, o_echo_mode;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [47:0] o_dac_code;
  logic [1:0] o_bresp, o_rresp, rr;
  logic [11:0] inr [4]; // Expected input registers
  logic [11:0] dac [4]; // Expected DAC registers
  logic sd, uo, em; // Expected shutdown, user out, echo mode
  logic [15:0] cap, pat;
  logic [63:0] seen_all;
  int err_count, cmp_count, cyc;
  assign seen_all = 64'({o_shutdown, o_user_logic_out, o_echo_mode, o_dac_code});
  qdc_dac_port i_qdc_dac_port (.*);
  qdc_host_model i_qdc_host_model (.i_clk_sys, .i_echo_out(o_echo_out), .o_shift_clk(i_shift_clk),
    .o_serial_in(i_serial_in), .o_select_n(i_select_n));
  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  // *****
  // Tasks
  // *****
  task automatic tally_and_finish();
    if (err_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Whole run needs about 4300 cycles
  initial begin
    cyc = 0;
    forever begin
      @(posedge i_clk_sys);
      cyc++;
      if (cyc == 12000) begin
        err_count++;
        tally_and_finish();
      end
    end
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [63:0] exp_all();
    return 64'({sd, uo, em, dac[3], dac[2], dac[1], dac[0]});
  endfunction
  // Applies one decoded frame to the expected state
  function automatic void expect_cmd(input logic [15:0] w);
    if (w[13:12] == qdc_pkg::CTL_LOAD) inr[w[15:14]] = w[11:0];
    else if (w[13:12] == qdc_pkg::CTL_LOAD_UPD) begin
      inr[w[15:14]] = w[11:0];
      dac = inr;
      sd = 1'b0;
    end else case (w[15:12])
      qdc_pkg::CMD_BROADCAST: begin
        inr = '{4{w[11:0]}};
        dac = inr;
        sd = 1'b0;
      end
      qdc_pkg::CMD_RECALL, qdc_pkg::CMD_ECHO_FALL, qdc_pkg::CMD_ECHO_RISE: begin
        dac = inr;
        sd = 1'b0;
        if (w[15:12] != qdc_pkg::CMD_RECALL) em = (w[15:12] == qdc_pkg::CMD_ECHO_RISE);
      end
      qdc_pkg::CMD_SHUTDOWN: if (i_shutdown_lockout_n) sd = 1'b1;
      qdc_pkg::CMD_OUT_LOW: uo = 1'b0;
      qdc_pkg::CMD_OUT_HIGH: uo = 1'b1;
      default: ;
    endcase
  endfunction
  // Sends a frame (with optional leading junk bits), then checks DAC codes, shutdown, user output and echo mode
  task automatic cmd(input logic [15:0] w, input logic [3:0] pre = 4'h0, input int n = 16);
    logic [15:0] c;
    i_qdc_host_model.send({12'h0, pre, w}, n, 1'b1, 4, c);
    repeat (8) @(posedge i_clk_sys);
    expect_cmd(w);
    chk(seen_all, exp_all());
  endtask
  // Response ready stalls at random
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge i_clk_sys);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    forever begin
      @(posedge i_clk_sys);
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
      if (o_bvalid && i_bready) begin
        r = o_bresp;
        i_bready <= 1'b0;
        break;
      end
      if ($urandom_range(1, 0) == 1) i_bready <= 1'b1;
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge i_clk_sys);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    forever begin
      @(posedge i_clk_sys);
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
      if (o_rvalid && i_rready) begin
        d = o_rdata;
        r = o_rresp;
        i_rready <= 1'b0;
        break;
      end
      if ($urandom_range(1, 0) == 1) i_rready <= 1'b1;
    end
  endtask
  // *****
  // Main sequence
  // *****
  initial begin
    {i_rst, i_clear_all_n, i_shutdown_lockout_n} = 3'h7;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
    {i_awaddr, i_araddr, i_wdata, i_wstrb} = 52'h0_0000_0000_000F;
    {err_count, cmp_count, sd, uo, em} = '0;
    dac = '{4{12'h000}};
    inr = dac;
    void'($urandom(93));
    repeat (6) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    chk(seen_all, exp_all());
    axi_rd(qdc_pkg::OFS_IN_BASE + 8'h0C, rd, rr);
    chk(64'(rd), 64'h0);
    // Unmapped read and read-only write are refused
    axi_rd(8'h40, rd, rr);
    chk(64'({rd, rr}), 64'(qdc_pkg::RESP_SLVERR));
    axi_wr(qdc_pkg::OFS_STATUS, 32'hFFFFFFFF, rr);
    chk(64'(rr), 64'(qdc_pkg::RESP_SLVERR));
    for (int ch = 0; ch < 4; ch++) begin
      cmd({ch[1:0], qdc_pkg::CTL_LOAD, 12'($urandom)});
      axi_rd(qdc_pkg::OFS_IN_BASE + 8'(4 * ch), rd, rr);
      chk(64'(rd), 64'(inr[ch]));
    end
    cmd({2'($urandom), qdc_pkg::CTL_LOAD_UPD, 12'hFFF});
    cmd({qdc_pkg::CMD_NOP, 12'($urandom)});
    cmd({2'h2, qdc_pkg::CTL_LOAD, 12'h000});
    cmd({qdc_pkg::CMD_RECALL, 12'hABC});
    // Shutdown refused when locked out
    i_shutdown_lockout_n <= 1'b0;
    cmd({qdc_pkg::CMD_SHUTDOWN, 12'h000});
    i_shutdown_lockout_n <= 1'b1;
    cmd({qdc_pkg::CMD_SHUTDOWN, 12'h000});
    cmd({2'h1, qdc_pkg::CTL_LOAD, 12'($urandom)});
    cmd({qdc_pkg::CMD_RECALL, 12'h000});
    // Lockout fall wakes with codes kept
    cmd({qdc_pkg::CMD_SHUTDOWN, 12'h000});
    i_shutdown_lockout_n <= 1'b0;
    repeat (8) @(posedge i_clk_sys);
    sd = 1'b0;
    chk(seen_all, exp_all());
    i_shutdown_lockout_n <= 1'b1;
    cmd({qdc_pkg::CMD_SHUTDOWN, 12'h000});
    cmd({qdc_pkg::CMD_BROADCAST, 12'($urandom)});
    cmd({qdc_pkg::CMD_OUT_HIGH, 12'hFFF});
    cmd({qdc_pkg::CMD_OUT_LOW, 12'hFFF});
    // Echo lag: fall mode trails rise mode by half a clock
    for (int m = 0; m < 2; m++) begin
      cmd({(m == 0) ? qdc_pkg::CMD_ECHO_FALL : qdc_pkg::CMD_ECHO_RISE, 12'h000});
      pat = {4'h0, 12'($urandom)};
      i_qdc_host_model.send(32'(pat), 16, 1'b1, 8, cap);
      i_qdc_host_model.send(32'h0, 16, 1'b1, 8, cap);
      chk(m == 0 ? 64'(cap[14:0]) : 64'(cap), m == 0 ? 64'(pat[15:1]) : 64'(pat));
    end
    // Twenty clocks: only the last sixteen decode
    cmd({2'h3, qdc_pkg::CTL_LOAD_UPD, 12'($urandom)}, 4'hF, 20);
    // Shift clocks with select high change nothing
    i_qdc_host_model.send({16'h0, qdc_pkg::CMD_BROADCAST, 12'h5A5}, 16, 1'b0, 4, cap);
    repeat (8) @(posedge i_clk_sys);
    chk(seen_all, exp_all());
    cmd({qdc_pkg::CMD_OUT_HIGH, 12'h000});
    // Clear zeroes codes and outputs, keeps echo mode
    i_clear_all_n <= 1'b0;
    repeat (8) @(posedge i_clk_sys);
    {uo, sd} = 2'h0;
    dac = '{4{12'h000}};
    inr = dac;
    chk(seen_all, exp_all());
    chk(64'(o_echo_out), 64'h0);
    i_clear_all_n <= 1'b1;
    axi_rd(qdc_pkg::OFS_IN_BASE, rd, rr);
    chk(64'(rd), 64'h0);
    tally_and_finish();
  end
endmodule // qdc_dac_port_tb_top
